// >>> verilog/dpllc_consts.vh
// Behaviour
// RULE1 - lock lasts 4N(11D+28) reference cycles; D from N, fin, M, xmin, capped 7
// RULE2 - xmin is ten delay-chain stages at minimum delay, 5.6 ns
// RULE3 - any control write drops a locked PLL to bypass
// RULE4 - after a control write, relock or stay bypassed per new contents
// RULE5 - regulator powered down whenever its power-down input is high
// RULE6 - power-down low and sleep high: sleep, regulator off, core switch closed
// RULE7 - sleep low opens the switch; with power-down low regulator is active
// RULE8 - steady flag high only when active and output nearly final
// RULE9 - power-on reset holds regulator powered down until inputs settle
// RULE10 - reset mode 0 takes system clock on oscillator input, alternate unused
// RULE11 - reset mode 1 takes only external 19.2 MHz on alternate input
// RULE12 - software keeps pin-mux select at 000 when oscillator input used
// RULE13 - oscillator power-down bit 1 disables the crystal oscillator
// RULE14 - oscillator hi-z bit 1 disables square-wave input clocks
// RULE15 - power-on reset loads 32 ms delay; clock held until it reaches 0
// RULE16 - while delay nonzero device and power manager stay in deep sleep
// RULE17 - software may rewrite the delay to zero via analog setup register
// RULE18 - enable 1 requests lock sequence then synthesized clock; 0 bypass
// RULE19 - bypass output is reference divided by 1, 2 or 4
// RULE20 - lock status 1 only when locked, 0 in bypass
// RULE21 - lock-break reads 0 after loss, 1 on relock or control write
// RULE22 - bypass clock kept for whole lock count, then synth and lock set
`ifndef DPLLC_CONSTS_VH
`define DPLLC_CONSTS_VH
// ==========================================
// register offsets
`define DPLLC_OFS_CTRL 12'h000
`define DPLLC_OFS_REGU 12'h004
`define DPLLC_OFS_CONF 12'h008
`define DPLLC_OFS_PMUX 12'h00C
`define DPLLC_OFS_ASET 12'h010
// ==========================================
// control and config field positions
`define DPLLC_CTRL_LOCK 0
`define DPLLC_CTRL_BRKN 1
`define DPLLC_CTRL_BDIV_LO 2
`define DPLLC_CTRL_EN 4
`define DPLLC_CTRL_DIV_LO 5
`define DPLLC_CTRL_MULT_LO 7
`define DPLLC_CONF_REG_POWERDOWN_IN 0
`define DPLLC_CONF_HIZ 1
// ==========================================
// reset values
`define DPLLC_CTRL_RST 10'h000
`define DPLLC_REGU_RST 2'h0
`define DPLLC_CONF_RST 2'h0
`define DPLLC_PMUX_RST 3'h0
// ==========================================
// timing
`define DPLLC_CLK_KHZ 25000
`define DPLLC_XMIN_NS_X10 56
`define DPLLC_CHAIN_STAGES 10
`define DPLLC_D_MAX 7
`define DPLLC_LOCK_A 11
`define DPLLC_LOCK_B 28
`define DPLLC_OSC_DELAY_MS 32
`define DPLLC_POR_SETTLE_CYC 16
`define DPLLC_X_SCALE 40'h98_9680
// regulator modes
`define DPLLC_RM_ACTIVE 2'h0
`define DPLLC_RM_SLEEP 2'h1
`define DPLLC_RM_PDN 2'h2
`endif

// >>> verilog/dpllc_top.v
// The APB slave port and the address map were decided locally.
`include "dpllc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module dpllc_top #(
	parameter [19:0] OSC_DELAY_CYC = 20'd`DPLLC_OSC_DELAY_MS * 20'd`DPLLC_CLK_KHZ
) (
	input wire clk_sys, // reference clock
	input wire rst_b, // async reset, active low
	input wire ce, // clock enable, freezes all state
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error
	input wire pll_lock_lost, // pulse: analog loop lost lock
	input wire reg_rail_near_final, // regulator output near final level
	input wire rst_mode_in, // reset mode strap
	output reg clkout_tick_r, // output clock enable
	output reg synth_active_r, // output carries synthesized clock
	output reg [1:0] reg_mode_r, // regulator mode
	output reg reg_switch_closed_r, // core-to-rail switch closed
	output reg reg_steady_r, // regulator steady flag
	output reg sysosc_enable_r, // crystal oscillator enabled
	output reg sysosc_sqwave_en_r, // square-wave input enabled
	output reg alt_sysclk_sel_r, // system clock from alternate input
	output reg clk_dist_en_r, // system clock distribution enabled
	output reg pm_deep_sleep_hold_r // power manager held in deep sleep
);
// ==========================================
// state encodings
localparam [1:0] ST_BYP = 2'h0;
localparam [1:0] ST_LOCKING = 2'h1;
localparam [1:0] ST_LOCKED = 2'h2;
// xmin spans ten chain stages at min delay
localparam [39:0] XMIN_DEN = 40'd`DPLLC_CLK_KHZ * 40'd`DPLLC_XMIN_NS_X10; // see RULE2
// ==========================================
// registers
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [11:0] lock_cnt_r;
reg [11:0] lock_cnt_nxt;
reg brk_n_r;
reg brk_n_nxt;
reg [1:0] bypass_div_r;
reg pll_en_r;
reg [1:0] pll_div_r;
reg [4:0] synth_multiplier_r;
reg reg_powerdown_in_r;
reg reg_sleep_in_r;
reg sysosc_powerdown_cfg_r;
reg sysosc_hiz_cfg_r;
reg [2:0] pinmux_select_d_r;
reg [19:0] osc_timer_r;
reg [4:0] por_cnt_r;
reg mode_cap_r;
reg rst_mode_r;
reg [1:0] div_cnt_r;
reg [31:0] rd_nxt;
reg err_nxt;
// ==========================================
// apb decode
wire setup_ph = psel & ~penable;
wire acc_ph = psel & penable & pready;
wire wr_acc = acc_ph & pwrite & ~pslverr;
wire wr_ctrl = wr_acc & (paddr == `DPLLC_OFS_CTRL);
wire wr_regu = wr_acc & (paddr == `DPLLC_OFS_REGU);
wire wr_conf = wr_acc & (paddr == `DPLLC_OFS_CONF);
wire wr_pmux = wr_acc & (paddr == `DPLLC_OFS_PMUX);
wire wr_aset = wr_acc & (paddr == `DPLLC_OFS_ASET);
wire new_en = pwdata[`DPLLC_CTRL_EN];
wire [1:0] new_div = pwdata[`DPLLC_CTRL_DIV_LO+1:`DPLLC_CTRL_DIV_LO];
wire [4:0] new_mult = pwdata[`DPLLC_CTRL_MULT_LO+4:`DPLLC_CTRL_MULT_LO];
// ==========================================
// lock time
// smallest k with M*fin*xmin*2^k >= N, giving D = 1 + k; x of 1 or more gives D = 1
function [2:0] lock_d;
	input [1:0] dv;
	input [4:0] mult;
	reg [39:0] num;
	reg [39:0] den;
	integer k;
	begin
		num = ({38'h0, dv} + 40'h1) * `DPLLC_X_SCALE;
		den = ((mult < 5'h2) ? 40'h1 : {35'h0, mult}) * XMIN_DEN;
		lock_d = `DPLLC_D_MAX; // see RULE1
		for (k = `DPLLC_D_MAX - 1; k >= 0; k = k - 1) begin
			if ((den << k) >= num) begin
				lock_d = k[2:0] + 3'h1;
			end
		end
	end
endfunction
wire [2:0] new_d = lock_d(new_div, new_mult);
wire [2:0] new_n = {1'b0, new_div} + 3'h1;
wire [6:0] lock_term = 7'd`DPLLC_LOCK_A * {4'h0, new_d} + 7'd`DPLLC_LOCK_B;
// product widened first: 4N(11D+28) needs up to 11 bits
wire [9:0] new_prod = {7'h0, new_n} * {3'h0, lock_term};
wire [11:0] lock_cyc = {new_prod, 2'h0}; // see RULE1
// lock time for the settings currently held
wire [2:0] cur_d = lock_d(pll_div_r, synth_multiplier_r);
wire [2:0] cur_n = {1'b0, pll_div_r} + 3'h1;
wire [6:0] cur_term = 7'd`DPLLC_LOCK_A * {4'h0, cur_d} + 7'd`DPLLC_LOCK_B;
wire [9:0] cur_prod = {7'h0, cur_n} * {3'h0, cur_term};
wire [11:0] lock_cyc_cur = {cur_prod, 2'h0};
// ==========================================
// pll mode sequence
always @* begin
	state_nxt = state_r;
	lock_cnt_nxt = lock_cnt_r;
	brk_n_nxt = brk_n_r;
	if (wr_ctrl) begin
		// a locked loop always passes through bypass, see RULE3
		brk_n_nxt = 1'b1; // see RULE21
		if (new_en) begin
			state_nxt = ST_LOCKING; // see RULE4
			lock_cnt_nxt = lock_cyc - 12'h1;
		end else begin
			state_nxt = ST_BYP; // see RULE18
		end
	end else begin
		case (state_r)
			ST_BYP: begin
				state_nxt = ST_BYP;
			end
			ST_LOCKING: begin
				if (lock_cnt_r == 12'h0) begin
					state_nxt = ST_LOCKED; // see RULE22
					brk_n_nxt = 1'b1;
				end else begin
					lock_cnt_nxt = lock_cnt_r - 12'h1;
				end
			end
			ST_LOCKED: begin
				// loss drops to bypass and restarts the full lock count
				if (pll_lock_lost) begin
					brk_n_nxt = 1'b0; // see RULE21
					state_nxt = ST_LOCKING;
					lock_cnt_nxt = lock_cyc_cur - 12'h1;
				end
			end
			default: begin
				state_nxt = ST_BYP;
			end
		endcase
	end
end
// ==========================================
// bypass divider tick
reg tick_nxt;
always @* begin
	case (bypass_div_r) // see RULE19
		2'h0: tick_nxt = 1'b1;
		2'h1: tick_nxt = div_cnt_r[0];
		default: tick_nxt = (div_cnt_r == 2'h3);
	endcase
	if (state_nxt == ST_LOCKED) begin
		tick_nxt = 1'b1;
	end
end
// ==========================================
// regulator and clock source decode
wire por_hold = (por_cnt_r != 5'h0);
reg [1:0] rmode_nxt;
always @* begin
	if (por_hold || reg_powerdown_in_r) begin
		rmode_nxt = `DPLLC_RM_PDN; // see RULE5 RULE9
	end else if (reg_sleep_in_r) begin
		rmode_nxt = `DPLLC_RM_SLEEP; // see RULE6
	end else begin
		rmode_nxt = `DPLLC_RM_ACTIVE; // see RULE7
	end
end
// the sleep switch follows sleep only once power-down is released
wire sw_nxt = (rmode_nxt == `DPLLC_RM_SLEEP);
wire mode1 = mode_cap_r & rst_mode_r;
wire pmux_conflict = ~mode1 & (pinmux_select_d_r != 3'h0); // see RULE12
// ==========================================
// read mux, built in the setup phase so prdata leaves a flop
always @* begin
	rd_nxt = 32'h0000_0000;
	err_nxt = 1'b0;
	case (paddr)
		`DPLLC_OFS_CTRL: begin
			rd_nxt[`DPLLC_CTRL_LOCK] = (state_r == ST_LOCKED); // see RULE20
			rd_nxt[`DPLLC_CTRL_BRKN] = brk_n_r;
			rd_nxt[`DPLLC_CTRL_BDIV_LO+1:`DPLLC_CTRL_BDIV_LO] = bypass_div_r;
			rd_nxt[`DPLLC_CTRL_EN] = pll_en_r;
			rd_nxt[`DPLLC_CTRL_DIV_LO+1:`DPLLC_CTRL_DIV_LO] = pll_div_r;
			rd_nxt[`DPLLC_CTRL_MULT_LO+4:`DPLLC_CTRL_MULT_LO] = synth_multiplier_r;
		end
		`DPLLC_OFS_REGU: begin
			rd_nxt[5:0] = {reg_steady_r, reg_switch_closed_r, reg_mode_r,
				reg_sleep_in_r, reg_powerdown_in_r};
		end
		`DPLLC_OFS_CONF: begin
			rd_nxt[9:8] = {pmux_conflict, mode1};
			rd_nxt[1:0] = {sysosc_hiz_cfg_r, sysosc_powerdown_cfg_r};
		end
		`DPLLC_OFS_PMUX: begin
			rd_nxt[2:0] = pinmux_select_d_r;
		end
		`DPLLC_OFS_ASET: begin
			rd_nxt[19:0] = osc_timer_r;
		end
		default: begin
			err_nxt = 1'b1;
		end
	endcase
end
// ==========================================
// apb slave and software registers
always @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		prdata <= 32'h0000_0000;
		pready <= 1'b0;
		pslverr <= 1'b0;
		bypass_div_r <= 2'h0;
		pll_en_r <= 1'b0;
		pll_div_r <= 2'h0;
		synth_multiplier_r <= 5'h0;
		reg_powerdown_in_r <= 1'b0;
		reg_sleep_in_r <= 1'b0;
		sysosc_powerdown_cfg_r <= 1'b0;
		sysosc_hiz_cfg_r <= 1'b0;
		pinmux_select_d_r <= `DPLLC_PMUX_RST;
	end else if (ce) begin
		pready <= setup_ph;
		if (setup_ph) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
			pslverr <= err_nxt;
		end
		if (wr_ctrl) begin
			bypass_div_r <= pwdata[`DPLLC_CTRL_BDIV_LO+1:`DPLLC_CTRL_BDIV_LO];
			pll_en_r <= new_en;
			pll_div_r <= new_div;
			synth_multiplier_r <= new_mult;
		end
		if (wr_regu) begin
			{reg_sleep_in_r, reg_powerdown_in_r} <= pwdata[1:0];
		end
		if (wr_conf) begin
			sysosc_powerdown_cfg_r <= pwdata[`DPLLC_CONF_REG_POWERDOWN_IN];
			sysosc_hiz_cfg_r <= pwdata[`DPLLC_CONF_HIZ];
		end
		if (wr_pmux) begin
			pinmux_select_d_r <= pwdata[2:0];
		end
	end
end
// ==========================================
// pll state, oscillator delay, regulator and outputs
always @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		state_r <= ST_BYP;
		lock_cnt_r <= 12'h000;
		brk_n_r <= 1'b0;
		div_cnt_r <= 2'h0;
		osc_timer_r <= OSC_DELAY_CYC; // see RULE15
		por_cnt_r <= 5'd`DPLLC_POR_SETTLE_CYC;
		mode_cap_r <= 1'b0;
		rst_mode_r <= 1'b0;
		clkout_tick_r <= 1'b0;
		synth_active_r <= 1'b0;
		reg_mode_r <= `DPLLC_RM_PDN;
		reg_switch_closed_r <= 1'b0;
		reg_steady_r <= 1'b0;
		sysosc_enable_r <= 1'b0;
		sysosc_sqwave_en_r <= 1'b0;
		alt_sysclk_sel_r <= 1'b0;
		clk_dist_en_r <= 1'b0;
		pm_deep_sleep_hold_r <= 1'b1;
	end else if (ce) begin
		state_r <= state_nxt;
		lock_cnt_r <= lock_cnt_nxt;
		brk_n_r <= brk_n_nxt;
		div_cnt_r <= div_cnt_r + 2'h1;
		if (por_hold) begin
			por_cnt_r <= por_cnt_r - 5'h1;
		end
		// strap is caught once, the cycle after reset release
		if (!mode_cap_r) begin
			mode_cap_r <= 1'b1;
			rst_mode_r <= rst_mode_in;
		end
		// mode 1 has no oscillator start-up wait; software may also zero it
		if (!mode_cap_r && rst_mode_in) begin
			osc_timer_r <= 20'h0_0000;
		end else if (wr_aset) begin
			osc_timer_r <= pwdata[19:0]; // see RULE17
		end else if (osc_timer_r != 20'h0_0000) begin
			osc_timer_r <= osc_timer_r - 20'h0_0001;
		end
		clk_dist_en_r <= (osc_timer_r == 20'h0_0000); // see RULE15
		pm_deep_sleep_hold_r <= (osc_timer_r != 20'h0_0000); // see RULE16
		clkout_tick_r <= tick_nxt; // see RULE22
		synth_active_r <= (state_nxt == ST_LOCKED);
		reg_mode_r <= rmode_nxt;
		reg_switch_closed_r <= sw_nxt; // see RULE6 RULE7
		reg_steady_r <= (rmode_nxt == `DPLLC_RM_ACTIVE) & reg_rail_near_final; // see RULE8
		// oscillator input only in mode 0; mode 1 parks the oscillator
		alt_sysclk_sel_r <= mode_cap_r ? rst_mode_r : rst_mode_in; // see RULE10 RULE11
		sysosc_enable_r <= ~sysosc_powerdown_cfg_r & ~sysosc_hiz_cfg_r
			& ~(mode_cap_r ? rst_mode_r : rst_mode_in); // see RULE13
		sysosc_sqwave_en_r <= ~sysosc_hiz_cfg_r
			& ~(mode_cap_r ? rst_mode_r : rst_mode_in); // see RULE14
	end
end
endmodule
`default_nettype wire

// >>> verilog/dpllc_unused_placeholder_never.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> verification/dpllc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dpllc_checker #(
	parameter [19:0] OSC_DELAY_CYC = 20'h3_2
) (
	input wire logic clk_sys, // reference clock
	input wire logic rst_b, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic pready, // apb ready
	input wire logic reg_rail_near_final, // rail near final
	input wire logic clkout_tick_r, // output clock enable
	input wire logic synth_active_r, // synthesized clock out
	input wire logic [1:0] reg_mode_r, // regulator mode
	input wire logic reg_switch_closed_r, // core switch
	input wire logic reg_steady_r, // steady flag
	input wire logic sysosc_enable_r, // oscillator on
	input wire logic sysosc_sqwave_en_r, // square wave on
	input wire logic alt_sysclk_sel_r, // alternate input
	input wire logic clk_dist_en_r, // distribution on
	input wire logic pm_deep_sleep_hold_r // deep sleep hold
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ====
	// cycles since reset, saturating so it never wraps back into the window
	logic [19:0] cnt_r;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) cnt_r <= 20'h0;
		else if (cnt_r != 20'hF_FFFF) cnt_r <= cnt_r + 20'h1;
	end
	por_hold_a: assert property ($rose(rst_b) |-> (reg_mode_r == 2'h2) [*8])
		else $error("regulator left power-down early");
	pd_mode_a: assert property (reg_mode_r == 2'h2 |-> !reg_switch_closed_r && !reg_steady_r)
		else $error("power-down mode with switch or steady");
	sleep_sw_a: assert property (reg_switch_closed_r == (reg_mode_r == 2'h1))
		else $error("switch not tied to sleep mode");
	steady_a: assert property (reg_steady_r |-> $past(reg_rail_near_final))
		else $error("steady without rail near final");
	hold_a: assert property (pm_deep_sleep_hold_r == !clk_dist_en_r)
		else $error("deep sleep hold disagrees with distribution");
	dist_wait_a: assert property ((cnt_r < OSC_DELAY_CYC - 20'h2 && !alt_sysclk_sel_r)
		|-> !clk_dist_en_r)
		else $error("clock distributed before delay ran out");
	osc_en_a: assert property (sysosc_enable_r |-> sysosc_sqwave_en_r && !alt_sysclk_sel_r)
		else $error("oscillator enabled against config");
	ctrl_drop_a: assert property ((psel && penable && pready && pwrite && paddr == 12'h000)
		|-> ##[1:2] !synth_active_r)
		else $error("control write did not drop to bypass");
	synth_tick_a: assert property (synth_active_r |-> clkout_tick_r)
		else $error("synthesized clock without tick");
endmodule
bind dpllc_top dpllc_checker #(.OSC_DELAY_CYC(OSC_DELAY_CYC)) chk_u (.*);
`default_nettype wire

// >>> verification/dpllc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpllc_analog_model (
	input wire logic clk_sys, // reference clock
	input wire logic [1:0] reg_mode_r, // regulator mode
	output logic pll_lock_lost, // loop lost lock pulse
	output logic reg_rail_near_final // rail near final level
);
	// ====
	// rail needs a few cycles to charge after the regulator wakes
	logic [2:0] ramp_r = 3'h0;
	initial pll_lock_lost = 1'b0;
	always @(posedge clk_sys) begin
		if (reg_mode_r != 2'h0) ramp_r <= 3'h0;
		else if (ramp_r != 3'h5) ramp_r <= ramp_r + 3'h1;
	end
	assign reg_rail_near_final = (ramp_r == 3'h5);
	task lose_lock;
		@(posedge clk_sys);
		pll_lock_lost <= 1'b1;
		@(posedge clk_sys);
		pll_lock_lost <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`include "dpllc_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam [19:0] OSC_CYC = 20'h3_2;
	// n=1, m=2 at 25 MHz gives d=3, 4*(33+28) cycles from the write edge
	localparam int LOCK_CYC = 244;
	logic clk_sys = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, rst_mode_in = 1'b0, pready, pslverr, last_err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pll_lock_lost, reg_rail_near_final, clkout_tick_r, synth_active_r;
	logic reg_switch_closed_r, reg_steady_r, sysosc_enable_r, sysosc_sqwave_en_r;
	logic alt_sysclk_sel_r, clk_dist_en_r, pm_deep_sleep_hold_r;
	logic [1:0] reg_mode_r;
	int errors = 0, tests_run = 0, n, tk, i;
	int div_ticks [4] = '{20, 10, 5, 5};
	always #20 clk_sys = ~clk_sys;
	dpllc_top #(.OSC_DELAY_CYC(OSC_CYC)) dut_u (.*);
	dpllc_analog_model partner_u (.*);
	// ====
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) errors++;
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task wait_lock;
		n = 0;
		tk = 0;
		while (synth_active_r !== 1'b1 && n < 400) begin
			cyc(1);
			n++;
			if (n <= 200) tk += clkout_tick_r;
		end
	endtask
	task done(input string s);
		$display("test %s ended, mismatches so far %0d", s, errors);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ====
	// scenarios
	task t_boot;
		chk(reg_mode_r, `DPLLC_RM_PDN);
		chk(alt_sysclk_sel_r, 0);
		chk(clk_dist_en_r, 0);
		cyc(OSC_CYC + 4);
		chk(clk_dist_en_r, 1);
		chk(pm_deep_sleep_hold_r, 0);
		done("boot");
	endtask
	task t_regu;
		for (i = 3; i >= 0; i--) begin
			apb(1, `DPLLC_OFS_REGU, i);
			cyc(10);
			chk(reg_mode_r, i[0] ? `DPLLC_RM_PDN : (i[1] ? `DPLLC_RM_SLEEP : `DPLLC_RM_ACTIVE));
			chk(reg_switch_closed_r, i == 2);
			chk(reg_steady_r, i == 0);
		end
		done("regulator");
	endtask
	task t_lock;
		apb(1, `DPLLC_OFS_CTRL, 32'h0000_0118);
		wait_lock();
		chk(n, LOCK_CYC);
		chk(tk, 50);
		apb(0, `DPLLC_OFS_CTRL, 0);
		chk(rd, 32'h0000_011B);
		for (i = 0; i < 4; i++) begin
			apb(1, `DPLLC_OFS_CTRL, 32'h0000_0100 | (i << 2));
			cyc(2);
			tk = 0;
			repeat (20) begin
				cyc(1);
				tk += clkout_tick_r;
			end
			chk(tk, div_ticks[i]);
			chk(synth_active_r, 0);
			apb(0, `DPLLC_OFS_CTRL, 0);
			chk(rd, 32'h0000_0102 | (i << 2));
		end
		done("lock");
	endtask
	task t_loss;
		apb(1, `DPLLC_OFS_CTRL, 32'h0000_0110);
		wait_lock();
		partner_u.lose_lock();
		cyc(2);
		chk(synth_active_r, 0);
		apb(0, `DPLLC_OFS_CTRL, 0);
		chk(rd & 3, 0);
		wait_lock();
		apb(0, `DPLLC_OFS_CTRL, 0);
		chk(rd & 3, 3);
		done("loss");
	endtask
	task t_conf;
		for (i = 3; i >= 0; i--) begin
			apb(1, `DPLLC_OFS_CONF, i);
			cyc(2);
			chk(sysosc_enable_r, i == 0);
			chk(sysosc_sqwave_en_r, !i[1]);
		end
		apb(0, 12'h020, 0);
		chk(last_err, 1);
		chk(rd, 0);
		// pin-mux off zero in mode 0 is flagged; software then restores 000
		apb(1, `DPLLC_OFS_PMUX, 6);
		apb(0, `DPLLC_OFS_CONF, 0);
		chk(rd, 32'h0000_0200);
		apb(1, `DPLLC_OFS_PMUX, 0);
		apb(0, `DPLLC_OFS_CONF, 0);
		chk(rd, 0);
		// timer must not count while the clock enable is low
		apb(1, `DPLLC_OFS_ASET, 20);
		ce <= 1'b0;
		cyc(10);
		ce <= 1'b1;
		apb(0, `DPLLC_OFS_ASET, 0);
		chk(rd, 19);
		chk(clk_dist_en_r, 0);
		apb(1, `DPLLC_OFS_ASET, 0);
		cyc(2);
		chk(clk_dist_en_r, 1);
		done("config");
	endtask
	task t_mode1;
		rst_mode_in <= 1'b1;
		rst_b <= 1'b0;
		cyc(2);
		rst_b <= 1'b1;
		cyc(3);
		chk(alt_sysclk_sel_r, 1);
		chk(sysosc_sqwave_en_r, 0);
		chk(clk_dist_en_r, 1);
		done("mode1");
	endtask
	initial begin
		cyc(2);
		rst_b <= 1'b1;
		cyc(1);
		t_boot();
		t_regu();
		t_lock();
		t_loss();
		t_conf();
		t_mode1();
		conclude();
	end
	// whole run needs under 2000 cycles; this leaves ample slack
	initial begin
		#200000;
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
